// *** bench/sbm_slave_model.sv ***
`timescale 1ns/10ps
`include "sbm_consts.svh"

module sbm_slave_model
    import sbm_pkg::*;
(
    input  wire logic      clk_in,                     // bus clock
    input  wire logic      rst_in,                     // async reset, high
    input  wire logic      slow_in,                    // stretch answers
    input  wire sbm_sreq_t s_req_in [`SBM_NUM_SLAVES], // matrix requests
    output sbm_rsp_t       s_rsp_out [`SBM_NUM_SLAVES] // slave answers
);
    localparam logic [31:0] KEY = 32'h5A5A_0000;
    logic [31:0]                cyc_q;
    logic [3:0]                 cnt_q [`SBM_NUM_SLAVES];
    logic [`SBM_NUM_SLAVES-1:0] done_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        cyc_q <= rst_in ? 32'h0 : cyc_q + 32'h1;
        for (int i = 0; i < `SBM_NUM_SLAVES; i++)
        begin
            done_q[i] <= !rst_in && s_req_in[i].valid && !done_q[i] &&
                         cnt_q[i] >= (slow_in ? 4'h5 : 4'h0);
            cnt_q[i]  <= (!rst_in && s_req_in[i].valid && !done_q[i]) ?
                         cnt_q[i] + 4'h1 : 4'h0;
        end
    end

    // idle data lines wander so a stale value never looks right
    always_comb
    begin
        for (int i = 0; i < `SBM_NUM_SLAVES; i++)
        begin
            s_rsp_out[i].done  = done_q[i];
            s_rsp_out[i].err   = 1'b0;
            s_rsp_out[i].rdata = s_req_in[i].valid ?
                                 s_req_in[i].addr ^ KEY : cyc_q;
        end
    end
endmodule : sbm_slave_model

// *** bench/tb.sv ***
`timescale 1ns/10ps
`include "sbm_consts.svh"

module tb;
    import sbm_pkg::*;
    localparam logic [31:0] KEY = 32'h5A5A_0000;
    logic      clk_in = 1'b0;
    logic      rst_in = 1'b1;
    logic      slow   = 1'b0;
    logic      ce     = 1'b1;
    sbm_mreq_t m_req [10];
    sbm_rsp_t  m_rsp [10];
    sbm_sreq_t s_req [8];
    sbm_rsp_t  s_rsp [8];
    int        error_cnt   = 0;
    int        check_count = 0;
    int        cyc         = 0;
    logic [31:0] rb [13] = '{32'h0000_0000, 32'h0400_0000, 32'h0800_0000,
        32'h0C00_0000, 32'h1000_0000, 32'h2000_0000, 32'h2400_0000,
        32'h2400_4000, 32'hFF00_0000, 32'hFF20_0000, 32'hFF30_0000,
        32'hFFE0_0000, 32'hFFF0_0000};
    int rl [13] = '{26, 26, 26, 26, 28, 26, 14, 14, 12, 10, 20, 20, 20};
    int rs [13] = '{4, 4, 4, 4, 4, 4, 0, 1, 6, 7, 5, 2, 3};
    logic [5:0] re [13] = '{6'h01, 6'h10, 6'h04, 6'h08, 6'h02, 6'h20,
        6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
    logic [31:0] gap [6] = '{32'h2400_8000, 32'h3000_0000, 32'hFF00_1000,
        32'hFF20_0400, 32'hFF40_0000, 32'hFEFF_FFFC};

    sbm_matrix #(.NUM_MASTERS(10), .FIXED_PRIO(8'h02)) dut_u (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce),
        .m_req_in  (m_req),
        .m_rsp_out (m_rsp),
        .s_req_out (s_req),
        .s_rsp_in  (s_rsp)
    );

    sbm_slave_model slv_u (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .slow_in   (slow),
        .s_req_in  (s_req),
        .s_rsp_out (s_rsp)
    );

    always #12.5 clk_in = ~clk_in;

    // far above the few hundred cycles the tests need
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task end_sim;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            error_cnt++;
        end
    endtask : chk

    function automatic int route(input logic [31:0] a, output logic [5:0] es);
        es = 6'h00;
        for (int i = 0; i < 13; i++)
            if ((a >> rl[i]) == (rb[i] >> rl[i]))
            begin
                es = re[i];
                return rs[i];
            end
        return -1;
    endfunction : route

    function automatic logic [31:0] rnd_addr(input int i);
        if (i >= 13)
            return gap[i - 13];
        return rb[i] + ($urandom & ((32'h1 << rl[i]) - 32'h1) & 32'hFFFF_FFFC);
    endfunction : rnd_addr

    // called at a falling edge; valid drops at the falling edge after done,
    // a still-held valid would be taken again as a fresh request
    task automatic acc(input int m, input logic [31:0] a, input logic w,
                       input bit lat);
        int          s;
        int          got;
        int          n;
        logic [5:0]  es;
        logic [5:0]  ges;
        logic [32:0] gwd;
        logic [31:0] wd;
        s = route(a, es);
        got = -1;
        ges = 6'h00;
        gwd = '0;
        n = 0;
        wd = $urandom;
        m_req[m] = '{1'b1, w, a, wd};
        do
        begin
            @(posedge clk_in);
            #1;
            n++;
            for (int i = 0; i < 8; i++)
                if (s_req[i].valid === 1'b1 && s_req[i].addr === a &&
                    s_req[i].master === m[3:0])
                begin
                    got = i;
                    ges = s_req[i].ext_sel;
                    gwd = {s_req[i].write, s_req[i].wdata};
                end
        end while (m_rsp[m].done !== 1'b1 && n < 100);
        chk("done", m_rsp[m].done, 1);
        chk("slv", got, s);
        chk("ext_sel", ges, es);
        chk("err", m_rsp[m].err, s < 0);
        if (s >= 0)
            chk("wdata", gwd, {w, wd});
        if (!w || s < 0)
            chk("rdata", m_rsp[m].rdata, s < 0 ? 0 : a ^ KEY);
        if (lat)
            chk("latency", n, s < 0 ? 1 : s < 2 ? 2 : slow ? 8 : 3);
        @(negedge clk_in);
        m_req[m].valid = 1'b0;
        @(negedge clk_in);
    endtask : acc

    task run_map;
        for (int i = 0; i < 13; i++)
        begin
            acc(i % 10, rb[i], 1'b0, 1'b1);
            acc(i % 10, rb[i] + (32'h1 << rl[i]) - 32'h4, 1'b1, 1'b1);
            m_req[i % 10].valid = 1'b0;
        end
        for (int i = 0; i < 6; i++)
        begin
            acc(i, gap[i], 1'b0, 1'b1);
            m_req[i].valid = 1'b0;
        end
        $display("test address map finished");
    endtask : run_map

    // every master at once; sel below 0 picks a region at random
    task automatic round(input int sel);
        for (int m = 0; m < 10; m++)
        begin
            automatic int          mm = m;
            automatic logic [31:0] aa = rnd_addr(sel < 0 ? $urandom % 19 : sel);
            automatic logic        ww = $urandom;
            fork
                acc(mm, aa, ww, 1'b0);
            join_none
        end
        wait fork;
        for (int m = 0; m < 10; m++)
            m_req[m].valid = 1'b0;
        @(negedge clk_in);
    endtask : round

    initial
    begin
        for (int m = 0; m < 10; m++)
            m_req[m] = '0;
        void'($urandom(32'h58739d66));
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        run_map();
        round(6);
        round(7);
        $display("test contention finished");
        repeat (8)
        begin
            slow = $urandom;
            round(-1);
        end
        $display("test random traffic finished");
        rst_in = 1'b1;
        repeat (3) @(negedge clk_in);
        for (int i = 0; i < 8; i++)
            chk("reset", {m_rsp[i].done, s_req[i].valid}, 0);
        rst_in = 1'b0;
        slow = 1'b1;
        @(negedge clk_in);
        // frozen matrix must not answer even an unmapped request
        ce = 1'b0;
        m_req[0] = '{1'b1, 1'b0, gap[1], 32'h0};
        repeat (3) @(negedge clk_in);
        chk("ce_hold", m_rsp[0].done, 0);
        m_req[0].valid = 1'b0;
        ce = 1'b1;
        @(negedge clk_in);
        run_map();
        $display("test map after reset finished");
        end_sim();
    end
endmodule : tb

// *** verilog/sbm_arbiter.sv ***
`timescale 1ns/10ps
`include "sbm_consts.svh"

module sbm_arbiter
    import sbm_pkg::*;
#(
    parameter int   NM    = `SBM_NUM_MASTERS,
    parameter logic FIXED = 1'b0
)
(
    input  wire logic                  clk_in,  // system bus clock
    input  wire logic                  rst_in,  // async reset, high
    input  wire logic                  ce_in,   // clock enable
    input  wire logic [NM-1:0]         req_in,  // masters asking
    input  wire logic                  done_in, // current transfer ends
    output logic                       take_out, // new grant this cycle
    output logic [`SBM_MID_W-1:0]      idx_out  // granted master
);

    logic                  busy_q;
    logic                  busy_d;
    logic [`SBM_MID_W-1:0] owner_q;
    logic [`SBM_MID_W-1:0] owner_d;
    logic [`SBM_MID_W-1:0] last_q;
    logic [`SBM_MID_W-1:0] last_d;

    always_comb
    begin
        int   j;
        logic found;
        j       = 0;
        found   = 1'b0;
        idx_out = '0;
        // fixed priority favours low numbers; rotating avoids starvation
        for (int i = 0; i < NM; i++)
        begin
            j = FIXED ? i : (int'(last_q) + 1 + i) % NM;
            if (!found && req_in[j])
            begin
                found   = 1'b1;
                idx_out = `SBM_MID_W'(j);
            end
        end
        take_out = (!busy_q || done_in) && found;
        busy_d   = busy_q;
        owner_d  = owner_q;
        last_d   = last_q;
        if (take_out)
        begin
            busy_d  = 1'b1;
            owner_d = idx_out;
            last_d  = idx_out;
        end
        else if (done_in)
            busy_d = 1'b0;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            busy_q  <= 1'b0;
            owner_q <= '0;
            last_q  <= '0;
        end
        else if (ce_in)
        begin
            busy_q  <= busy_d;
            owner_q <= owner_d;
            last_q  <= last_d;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_grant_held: assert property (
        ce_in && busy_q && !done_in
        |=> busy_q && $stable(owner_q) && (!take_out || done_in))
        else $error("grant moved before transfer ended");
    a_grant_real: assert property (
        take_out |-> req_in[idx_out] && $onehot(req_in & (NM'(1) << idx_out)))
        else $error("grant to a master that is not asking");

endmodule : sbm_arbiter

// *** verilog/sbm_consts.svh ***
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH

`define SBM_ADDR_W          32
`define SBM_DATA_W          32
`define SBM_MID_W           4
`define SBM_SID_W           3
`define SBM_NUM_MASTERS     10
`define SBM_MAX_MASTERS     16
`define SBM_NUM_SLAVES      8
`define SBM_EXT_SEL_W       6

`define SBM_SZ_64M          26
`define SBM_SZ_256M         28
`define SBM_SZ_16K          14
`define SBM_SZ_4K           12
`define SBM_SZ_1K           10
`define SBM_SZ_1M           20

`define SBM_EXT0_BASE       32'h0000_0000
`define SBM_EXT4_BASE       32'h0400_0000
`define SBM_EXT2_BASE       32'h0800_0000
`define SBM_EXT3_BASE       32'h0C00_0000
`define SBM_EXT1_BASE       32'h1000_0000
`define SBM_EXT5_BASE       32'h2000_0000
`define SBM_SRAM0_BASE      32'h2400_0000
`define SBM_SRAM1_BASE      32'h2400_4000
`define SBM_DISP_CFG_BASE   32'hFF00_0000
`define SBM_DMA_CFG_BASE    32'hFF20_0000
`define SBM_USB_DATA_BASE   32'hFF30_0000
`define SBM_BRIDGE_A_BASE   32'hFFE0_0000
`define SBM_BRIDGE_B_BASE   32'hFFF0_0000

`define SBM_EXT_SELECT_NONE  6'h00
`define SBM_EXT_SELECT_ZERO  6'h01
`define SBM_EXT_SELECT_ONE   6'h02
`define SBM_EXT_SELECT_TWO   6'h04
`define SBM_EXT_SELECT_THREE 6'h08
`define SBM_EXT_SELECT_FOUR  6'h10
`define SBM_EXT_SELECT_FIVE  6'h20

`endif

// *** verilog/sbm_decoder.sv ***
`timescale 1ns/10ps
`include "sbm_consts.svh"

module sbm_decoder
    import sbm_pkg::*;
(
    input  wire logic [`SBM_ADDR_W-1:0]    addr_in,    // master address
    output logic                           hit_out,    // address is mapped
    output sbm_slave_t                     slave_out,  // target slave
    output logic [`SBM_EXT_SEL_W-1:0]      ext_sel_out // one-hot select
);

    // hard-wired map, no remap input even while booting
    always_comb
    begin
        hit_out     = 1'b1;
        slave_out   = SBM_S_EXT_BUS;
        ext_sel_out = `SBM_EXT_SELECT_NONE;
        if (sbm_in_rgn(addr_in, `SBM_EXT0_BASE, `SBM_SZ_64M))
            ext_sel_out = `SBM_EXT_SELECT_ZERO;
        else if (sbm_in_rgn(addr_in, `SBM_EXT4_BASE, `SBM_SZ_64M))
            ext_sel_out = `SBM_EXT_SELECT_FOUR;
        else if (sbm_in_rgn(addr_in, `SBM_EXT2_BASE, `SBM_SZ_64M))
            ext_sel_out = `SBM_EXT_SELECT_TWO;
        else if (sbm_in_rgn(addr_in, `SBM_EXT3_BASE, `SBM_SZ_64M))
            ext_sel_out = `SBM_EXT_SELECT_THREE;
        else if (sbm_in_rgn(addr_in, `SBM_EXT1_BASE, `SBM_SZ_256M))
            ext_sel_out = `SBM_EXT_SELECT_ONE;
        else if (sbm_in_rgn(addr_in, `SBM_EXT5_BASE, `SBM_SZ_64M))
            ext_sel_out = `SBM_EXT_SELECT_FIVE;
        else if (sbm_in_rgn(addr_in, `SBM_SRAM0_BASE, `SBM_SZ_16K))
            slave_out = SBM_S_SRAM0;
        else if (sbm_in_rgn(addr_in, `SBM_SRAM1_BASE, `SBM_SZ_16K))
            slave_out = SBM_S_SRAM1;
        else if (sbm_in_rgn(addr_in, `SBM_DISP_CFG_BASE, `SBM_SZ_4K))
            slave_out = SBM_S_DISPLAY_CFG;
        else if (sbm_in_rgn(addr_in, `SBM_DMA_CFG_BASE, `SBM_SZ_1K))
            slave_out = SBM_S_DMA_CFG;
        else if (sbm_in_rgn(addr_in, `SBM_USB_DATA_BASE, `SBM_SZ_1M))
            slave_out = SBM_S_USB_DATA;
        else if (sbm_in_rgn(addr_in, `SBM_BRIDGE_A_BASE, `SBM_SZ_1M))
            slave_out = SBM_S_PERIPH_BRIDGE_A;
        else if (sbm_in_rgn(addr_in, `SBM_BRIDGE_B_BASE, `SBM_SZ_1M))
            slave_out = SBM_S_PERIPH_BRIDGE_B;
        else
            hit_out = 1'b0;
    end

endmodule : sbm_decoder

// *** verilog/sbm_matrix.sv ***
`timescale 1ns/10ps
`include "sbm_consts.svh"

module sbm_matrix
    import sbm_pkg::*;
#(
    parameter int                          NUM_MASTERS = `SBM_NUM_MASTERS,
    parameter logic [`SBM_NUM_SLAVES-1:0]  FIXED_PRIO  = '0
)
(
    input  wire logic  clk_in,                         // system bus clock
    input  wire logic  rst_in,                         // async reset, high
    input  wire logic  ce_in,                          // clock enable
    input  wire sbm_mreq_t m_req_in [NUM_MASTERS],     // master requests
    output sbm_rsp_t   m_rsp_out [NUM_MASTERS],        // master answers
    output sbm_sreq_t  s_req_out [`SBM_NUM_SLAVES],    // slave requests
    input  wire sbm_rsp_t s_rsp_in [`SBM_NUM_SLAVES]   // slave answers
);

    localparam int NM  = NUM_MASTERS;
    localparam int NS  = `SBM_NUM_SLAVES;
    localparam int EXT = int'(SBM_S_EXT_BUS);

    if (NM < 1 || NM > `SBM_MAX_MASTERS)
    begin : g_bad_nm
        $error("NUM_MASTERS out of range 1..16");
    end

    logic [NM-1:0]                 elig;
    logic [NM-1:0]                 hit;
    logic [NM-1:0]                 pend_q;
    logic [NM-1:0]                 pend_d;
    sbm_slave_t                    dsl  [NM];
    logic [`SBM_EXT_SEL_W-1:0]     dext [NM];
    logic [NM-1:0]                 sreq [NS];
    logic [NS-1:0]                 take;
    logic [NS-1:0]                 sdone;
    logic [`SBM_MID_W-1:0]         tidx [NS];
    sbm_sreq_t                     sq_q [NS];
    sbm_sreq_t                     sq_d [NS];
    sbm_rsp_t                      mr_q [NM];
    sbm_rsp_t                      mr_d [NM];

    for (genvar m = 0; m < NM; m++)
    begin : g_dec
        sbm_decoder u_dec
        (
            .addr_in     (m_req_in[m].addr),
            .hit_out     (hit[m]),
            .slave_out   (dsl[m]),
            .ext_sel_out (dext[m])
        );
    end

    for (genvar s = 0; s < NS; s++)
    begin : g_arb
        sbm_arbiter #(
            .NM    (NM),
            .FIXED (FIXED_PRIO[s])
        ) u_arb
        (
            .clk_in   (clk_in),
            .rst_in   (rst_in),
            .ce_in    (ce_in),
            .req_in   (sreq[s]),
            .done_in  (sdone[s]),
            .take_out (take[s]),
            .idx_out  (tidx[s])
        );
    end

    // a master is eligible only once per request: while pending, and in
    // the cycle its answer shows, its still-held valid is not a new one
    always_comb
    begin
        for (int m = 0; m < NM; m++)
            elig[m] = m_req_in[m].valid && !pend_q[m] && !mr_q[m].done;
        for (int s = 0; s < NS; s++)
        begin
            for (int m = 0; m < NM; m++)
                sreq[s][m] = elig[m] && hit[m]
                    && (dsl[m] == sbm_slave_t'(`SBM_SID_W'(s)));
            // SRAM answers in the cycle it is addressed, no wait state
            if (s == int'(SBM_S_SRAM0) || s == int'(SBM_S_SRAM1))
                sdone[s] = sq_q[s].valid;
            else
                sdone[s] = sq_q[s].valid && s_rsp_in[s].done;
        end
    end

    // slave side: a new grant may follow a finishing one back to back
    always_comb
    begin
        for (int s = 0; s < NS; s++)
        begin
            sq_d[s] = sq_q[s];
            if (take[s])
            begin
                sq_d[s].valid   = 1'b1;
                sq_d[s].write   = m_req_in[tidx[s]].write;
                sq_d[s].master  = tidx[s];
                sq_d[s].addr    = m_req_in[tidx[s]].addr;
                sq_d[s].wdata   = m_req_in[tidx[s]].wdata;
                sq_d[s].ext_sel = dext[tidx[s]];
            end
            else if (sdone[s])
                sq_d[s].valid = 1'b0;
        end
    end

    // master side: done and err are one-cycle pulses, rdata holds
    always_comb
    begin
        pend_d = pend_q;
        for (int m = 0; m < NM; m++)
        begin
            mr_d[m]      = mr_q[m];
            mr_d[m].done = 1'b0;
            mr_d[m].err  = 1'b0;
            if (elig[m] && !hit[m])
            begin
                mr_d[m].done  = 1'b1;
                mr_d[m].err   = 1'b1;
                mr_d[m].rdata = '0;
            end
        end
        for (int s = 0; s < NS; s++)
        begin
            if (sdone[s])
            begin
                mr_d[sq_q[s].master].done  = 1'b1;
                mr_d[sq_q[s].master].err   = s_rsp_in[s].err;
                mr_d[sq_q[s].master].rdata = s_rsp_in[s].rdata;
                pend_d[sq_q[s].master]     = 1'b0;
            end
            if (take[s])
                pend_d[tidx[s]] = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pend_q <= '0;
            for (int s = 0; s < NS; s++)
                sq_q[s] <= '0;
            for (int m = 0; m < NM; m++)
                mr_q[m] <= '0;
        end
        else if (ce_in)
        begin
            pend_q <= pend_d;
            for (int s = 0; s < NS; s++)
                sq_q[s] <= sq_d[s];
            for (int m = 0; m < NM; m++)
                mr_q[m] <= mr_d[m];
        end
    end

    assign s_req_out = sq_q;
    assign m_rsp_out = mr_q;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_ext_zero_sel: assert property (
        sq_q[EXT].valid
        && sbm_in_rgn(sq_q[EXT].addr, `SBM_EXT0_BASE, `SBM_SZ_64M)
        |-> sq_q[EXT].ext_sel == `SBM_EXT_SELECT_ZERO)
        else $error("select zero missing");
    a_ext_four_sel: assert property (
        sq_q[EXT].valid
        && sbm_in_rgn(sq_q[EXT].addr, `SBM_EXT4_BASE, `SBM_SZ_64M)
        |-> sq_q[EXT].ext_sel == `SBM_EXT_SELECT_FOUR)
        else $error("select four missing");
    a_ext_two_sel: assert property (
        sq_q[EXT].valid
        && sbm_in_rgn(sq_q[EXT].addr, `SBM_EXT2_BASE, `SBM_SZ_64M)
        |-> sq_q[EXT].ext_sel == `SBM_EXT_SELECT_TWO)
        else $error("select two missing");
    a_ext_three_sel: assert property (
        sq_q[EXT].valid
        && sbm_in_rgn(sq_q[EXT].addr, `SBM_EXT3_BASE, `SBM_SZ_64M)
        |-> sq_q[EXT].ext_sel == `SBM_EXT_SELECT_THREE)
        else $error("select three missing");
    a_ext_one_sel: assert property (
        sq_q[EXT].valid
        && sbm_in_rgn(sq_q[EXT].addr, `SBM_EXT1_BASE, `SBM_SZ_256M)
        |-> sq_q[EXT].ext_sel == `SBM_EXT_SELECT_ONE)
        else $error("select one missing");
    a_ext_five_sel: assert property (
        sq_q[EXT].valid
        && sbm_in_rgn(sq_q[EXT].addr, `SBM_EXT5_BASE, `SBM_SZ_64M)
        |-> sq_q[EXT].ext_sel == `SBM_EXT_SELECT_FIVE)
        else $error("select five missing");
    a_sram0_region: assert property (
        sq_q[0].valid |->
        sbm_in_rgn(sq_q[0].addr, `SBM_SRAM0_BASE, `SBM_SZ_16K))
        else $error("SRAM 0 outside its window");
    a_sram1_region: assert property (
        sq_q[1].valid |->
        sbm_in_rgn(sq_q[1].addr, `SBM_SRAM1_BASE, `SBM_SZ_16K))
        else $error("SRAM 1 outside its window");
    a_sram_single_cycle: assert property (
        ce_in && sq_q[0].valid |=> mr_q[$past(sq_q[0].master)].done)
        else $error("SRAM access took more than one cycle");
    a_disp_cfg_region: assert property (
        sq_q[6].valid |->
        sbm_in_rgn(sq_q[6].addr, `SBM_DISP_CFG_BASE, `SBM_SZ_4K))
        else $error("display config outside window");
    a_dma_cfg_region: assert property (
        sq_q[7].valid |->
        sbm_in_rgn(sq_q[7].addr, `SBM_DMA_CFG_BASE, `SBM_SZ_1K))
        else $error("DMA config outside window");
    a_usb_data_region: assert property (
        sq_q[5].valid |->
        sbm_in_rgn(sq_q[5].addr, `SBM_USB_DATA_BASE, `SBM_SZ_1M))
        else $error("USB data outside window");
    a_bridge_regions: assert property (
        (sq_q[2].valid |->
         sbm_in_rgn(sq_q[2].addr, `SBM_BRIDGE_A_BASE, `SBM_SZ_1M))
        and (sq_q[3].valid |->
         sbm_in_rgn(sq_q[3].addr, `SBM_BRIDGE_B_BASE, `SBM_SZ_1M)))
        else $error("bridge access outside window");

    for (genvar m = 0; m < NM; m++)
    begin : g_chk
        sequence s_bad_req;
            ce_in && elig[m] && !hit[m];
        endsequence
        sequence s_err_answer;
            mr_q[m].done && mr_q[m].err ##1 !mr_q[m].done;
        endsequence
        a_unmapped_err: assert property (
            s_bad_req |=> s_err_answer)
            else $error("unmapped access not answered with error");
    end

endmodule : sbm_matrix

// *** verilog/sbm_pkg.sv ***
`include "sbm_consts.svh"

package sbm_pkg;

    typedef enum logic [`SBM_MID_W-1:0] {
        SBM_M_DCACHE,
        SBM_M_ICACHE,
        SBM_M_BUS_BRIDGE,
        SBM_M_IMAGE_SENSOR_PORT,
        SBM_M_USB_DEVICE_PORT,
        SBM_M_DISPLAY_CONTROLLER,
        SBM_M_ETHERNET_PORT_ZERO,
        SBM_M_ETHERNET_PORT_ONE,
        SBM_M_DMA_ENGINE_PORT0,
        SBM_M_DMA_ENGINE_PORT1
    } sbm_master_t;

    typedef enum logic [`SBM_SID_W-1:0] {
        SBM_S_SRAM0,
        SBM_S_SRAM1,
        SBM_S_PERIPH_BRIDGE_A,
        SBM_S_PERIPH_BRIDGE_B,
        SBM_S_EXT_BUS,
        SBM_S_USB_DATA,
        SBM_S_DISPLAY_CFG,
        SBM_S_DMA_CFG
    } sbm_slave_t;

    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic [`SBM_ADDR_W-1:0] addr;
        logic [`SBM_DATA_W-1:0] wdata;
    } sbm_mreq_t;

    typedef struct packed {
        logic                   done;
        logic                   err;
        logic [`SBM_DATA_W-1:0] rdata;
    } sbm_rsp_t;

    typedef struct packed {
        logic                      valid;
        logic                      write;
        logic [`SBM_MID_W-1:0]     master;
        logic [`SBM_ADDR_W-1:0]    addr;
        logic [`SBM_DATA_W-1:0]    wdata;
        logic [`SBM_EXT_SEL_W-1:0] ext_sel;
    } sbm_sreq_t;

    function automatic logic sbm_in_rgn(
        input logic [`SBM_ADDR_W-1:0] a,
        input logic [`SBM_ADDR_W-1:0] base,
        input int                     lg
    );
        return (a >> lg) == (base >> lg);
    endfunction : sbm_in_rgn

endpackage : sbm_pkg
